// ### hw/mlprs_regs.vh
`ifndef MLPRS_REGS_VH
`define MLPRS_REGS_VH

// Block base, compared against haddr[31:8]
`define MLPRS_BASE_HI        24'h400000

// Register byte offsets within the block
`define MLPRS_OFF_SELF_TEST  8'h20
`define MLPRS_OFF_SYNC_CLR   8'h24
`define MLPRS_OFF_SYNC_STAT  8'h28
`define MLPRS_OFF_RES_CH0    8'h2C
`define MLPRS_OFF_RES_CH1    8'h30
`define MLPRS_OFF_RES_CH2    8'h34
`define MLPRS_OFF_RES_CH3    8'h38
`define MLPRS_OFF_TEST_CTRL  8'h3C
`define MLPRS_OFF_RUN_STAT   8'h40
`define MLPRS_OFF_INT_STAT   8'h44
`define MLPRS_OFF_INT_CLR    8'h48
`define MLPRS_OFF_INT_EN     8'h4C

// Test control fields
`define MLPRS_CTRL_RESET     32'h0FFF0000
`define MLPRS_CTRL_MASK      32'h0FFFFFFF
`define MLPRS_DUR_MSB        15
`define MLPRS_DUR_LSB        0
`define MLPRS_CHSEL_LSB      16
`define MLPRS_LANE_LSB       20
`define MLPRS_DUR_ZERO_MS    16'h000A

// Single-bit field positions
`define MLPRS_START_BIT      0
`define MLPRS_CLR_BIT        0
`define MLPRS_FLAG_BIT       0
`define MLPRS_INT_SYNC       0
`define MLPRS_INT_DONE       1
`define MLPRS_RUN_BIT        0

// Bus transfer size of one whole word
`define MLPRS_HSIZE_WORD     3'b010

// Timing
`define MLPRS_CLK_MHZ        200
`define MLPRS_MS_US          1000
`define MLPRS_CLR_HOLD_NS    500

`endif

// ### hw/mlprs_tick_div.v
`timescale 1ns/1ps
module mlprs_tick_div #(
    parameter DIV = 200000
) (
    input  wire clock_i,
    input  wire rst_i,
    input  wire enable_i,
    output reg  tick_o
);
    localparam [31:0] LAST = DIV - 1;

    reg [31:0] count;

    // Restarts with the enable so every run sees whole milliseconds
    always @(posedge clock_i) begin
        if (rst_i || !enable_i) begin
            count  <= 32'h00000000;
            tick_o <= 1'b0;
        end else if (count == LAST) begin
            count  <= 32'h00000000;
            tick_o <= 1'b1;
        end else begin
            count  <= count + 32'h00000001;
            tick_o <= 1'b0;
        end
    end
endmodule

// ### hw/mlprs_lane_check.v
`timescale 1ns/1ps
module mlprs_lane_check #(
    parameter LANES = 8
) (
    input  wire             clock_i,
    input  wire             rst_i,
    input  wire             start_i,
    input  wire             active_i,
    input  wire             done_i,
    input  wire [LANES-1:0] lane_sel_i,
    input  wire [LANES-1:0] lane_err_i,
    output reg  [LANES-1:0] result_o
);
    reg  [LANES-1:0] fail;
    wire [LANES-1:0] fail_now = fail | (lane_err_i & lane_sel_i);

    // A lane passes only if selected and error-free for the whole run
    always @(posedge clock_i) begin
        if (rst_i) begin
            fail     <= {LANES{1'b0}};
            result_o <= {LANES{1'b0}};
        end else if (start_i) begin
            fail     <= {LANES{1'b0}};
            result_o <= {LANES{1'b0}};
        end else begin
            if (active_i)
                fail <= fail_now;
            if (done_i)
                result_o <= lane_sel_i & ~fail_now;
        end
    end
endmodule

// ### hw/mlprs_top.v
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "mlprs_regs.vh"

module mlprs_top #(
    parameter CHANNELS  = 4,
    parameter LANES     = 8,
    parameter MS_CYCLES = `MLPRS_MS_US * `MLPRS_CLK_MHZ
) (
    input  wire                      clock_i,
    input  wire                      rst_i,
    input  wire                      hsel_i,
    input  wire [31:0]               haddr_i,
    input  wire [1:0]                htrans_i,
    input  wire                      hwrite_i,
    input  wire [2:0]                hsize_i,
    input  wire [31:0]               hwdata_i,
    input  wire                      hready_i,
    output reg  [31:0]               hrdata_o,
    output reg                       hreadyout_o,
    output reg                       hresp_o,
    input  wire                      sync_err_i,
    input  wire [CHANNELS*LANES-1:0] lane_err_i,
    output reg                       link_test_running_o,
    output reg  [CHANNELS*LANES-1:0] lane_test_sel_o,
    output reg                       irq_o
);
    // One flat bit per physical lane: bit c*LANES+l is channel c lane l
    localparam NL = CHANNELS * LANES;
    // The run window is ST_RUN alone; results latch the cycle after it closes
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_RUN  = 2'b01;

    // Input synchronisers; only the second stage is ever read
    reg          sync_s1;
    reg          sync_s2;
    reg [NL-1:0] lane_s1;
    reg [NL-1:0] lane_s2;

    always @(posedge clock_i) begin
        if (rst_i) begin
            sync_s1 <= 1'b0;
            sync_s2 <= 1'b0;
        end else begin
            sync_s1 <= sync_err_i;
            sync_s2 <= sync_s1;
        end
    end

    // Lane errors are independent bits, so per-bit synchronising is safe
    always @(posedge clock_i) begin
        if (rst_i) begin
            lane_s1 <= {NL{1'b0}};
            lane_s2 <= {NL{1'b0}};
        end else begin
            lane_s1 <= lane_err_i;
            lane_s2 <= lane_s1;
        end
    end

    // Bus slave state; a narrow write is dropped rather than merged into a word
    reg        wr_pend;
    reg        rd_pend;
    reg        ph_hit;
    reg        ph_word;
    reg [7:0]  ph_addr;
    wire       accept = hsel_i & htrans_i[1] & hready_i;
    wire       we     = wr_pend & ph_hit & ph_word;

    // Register, interrupt and sequencer state
    reg              sync_error_flag;
    reg              sync_latch_clear_bit;
    reg              start_pulse;
    reg [31:0]       test_ctrl;
    reg [1:0]        int_stat;
    reg [1:0]        int_en;
    reg [1:0]        state;
    reg [15:0]       ms_left;
    reg              done_pulse;
    reg [31:0]       rdata;
    wire [NL-1:0]    result_all;
    wire             ms_tick;

    wire [15:0] lane_test_duration = test_ctrl[`MLPRS_DUR_MSB:`MLPRS_DUR_LSB];
    wire [CHANNELS-1:0] ch_sel = test_ctrl[`MLPRS_CHSEL_LSB +: CHANNELS];
    wire [LANES-1:0]    ln_sel = test_ctrl[`MLPRS_LANE_LSB +: LANES];

    // Start is a strobe with no storage, so the bit can only ever read zero
    wire wr_start = we && (ph_addr == `MLPRS_OFF_SELF_TEST) && hwdata_i[`MLPRS_START_BIT];
    wire [1:0] int_clr = (we && (ph_addr == `MLPRS_OFF_INT_CLR)) ? hwdata_i[1:0] : 2'b00;
    // A held error raises one event, not one per cycle
    wire ev_sync = sync_s2 & ~sync_error_flag & ~sync_latch_clear_bit;
    wire [1:0] next_int_stat = (int_stat & ~int_clr)
                             | {done_pulse, ev_sync};

    // AHB-Lite: writes take no wait state, reads take one
    always @(posedge clock_i) begin
        if (rst_i) begin
            wr_pend     <= 1'b0;
            rd_pend     <= 1'b0;
            ph_hit      <= 1'b0;
            ph_word     <= 1'b0;
            ph_addr     <= 8'h00;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            hrdata_o    <= 32'h00000000;
        end else begin
            hresp_o <= 1'b0;
            if (rd_pend) begin
                hrdata_o    <= rdata;
                hreadyout_o <= 1'b1;
                rd_pend     <= 1'b0;
            end else if (accept) begin
                ph_addr     <= {haddr_i[7:2], 2'b00};
                ph_hit      <= (haddr_i[31:8] == `MLPRS_BASE_HI);
                ph_word     <= (hsize_i == `MLPRS_HSIZE_WORD);
                wr_pend     <= hwrite_i;
                rd_pend     <= ~hwrite_i;
                hreadyout_o <= hwrite_i;
            end else begin
                wr_pend <= 1'b0;
            end
            if (accept && hwrite_i == 1'b0)
                wr_pend <= 1'b0;
        end
    end

    // Register writes; unused bits never stored
    always @(posedge clock_i) begin
        if (rst_i) begin
            sync_latch_clear_bit <= 1'b0;
            test_ctrl            <= `MLPRS_CTRL_RESET;
            int_en               <= 2'b00;
        end else if (we) begin
            case (ph_addr)
                `MLPRS_OFF_SYNC_CLR: begin
                    sync_latch_clear_bit <= hwdata_i[`MLPRS_CLR_BIT];
                end
                `MLPRS_OFF_TEST_CTRL: begin
                    test_ctrl <= hwdata_i & `MLPRS_CTRL_MASK;
                end
                `MLPRS_OFF_INT_EN: begin
                    int_en <= hwdata_i[1:0];
                end
                default: begin
                    int_en <= int_en;
                end
            endcase
        end
    end

    // Sync error flag; clear bit dominates as long as it is held
    always @(posedge clock_i) begin
        if (rst_i)
            sync_error_flag <= 1'b0;
        else if (sync_latch_clear_bit)
            sync_error_flag <= 1'b0;
        else if (sync_s2)
            sync_error_flag <= 1'b1;
    end

    // Interrupt status: a new event wins over a same-cycle clear
    always @(posedge clock_i) begin
        if (rst_i) begin
            int_stat <= 2'b00;
            irq_o    <= 1'b0;
        end else begin
            int_stat <= next_int_stat;
            irq_o    <= |(next_int_stat & int_en);
        end
    end

    // Runs only in ST_RUN, so every run starts on a whole millisecond
    mlprs_tick_div #(
        .DIV (MS_CYCLES)
    ) u_ms_tick (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .enable_i (state == ST_RUN),
        .tick_o   (ms_tick)
    );

    // Test sequencer; a start while running is ignored
    always @(posedge clock_i) begin
        if (rst_i) begin
            state               <= ST_IDLE;
            ms_left             <= 16'h0000;
            start_pulse         <= 1'b0;
            done_pulse          <= 1'b0;
            link_test_running_o <= 1'b0;
            lane_test_sel_o     <= {NL{1'b0}};
        end else begin
            start_pulse <= 1'b0;
            done_pulse  <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (wr_start) begin
                        state               <= ST_RUN;
                        start_pulse         <= 1'b1;
                        link_test_running_o <= 1'b1;
                        lane_test_sel_o     <= lane_map(ch_sel, ln_sel);
                        if (lane_test_duration == 16'h0000)
                            ms_left <= `MLPRS_DUR_ZERO_MS;
                        else
                            ms_left <= lane_test_duration;
                    end
                end
                ST_RUN: begin
                    if (ms_tick) begin
                        if (ms_left == 16'h0001) begin
                            state               <= ST_IDLE;
                            done_pulse          <= 1'b1;
                            link_test_running_o <= 1'b0;
                        end
                        ms_left <= ms_left - 16'h0001;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Spreads channel and lane enables onto one bit per physical lane
    function [NL-1:0] lane_map;
        input [CHANNELS-1:0] chs;
        input [LANES-1:0]    lns;
        integer c;
        begin
            lane_map = {NL{1'b0}};
            for (c = 0; c < CHANNELS; c = c + 1)
                lane_map[c*LANES +: LANES] = chs[c] ? lns : {LANES{1'b0}};
        end
    endfunction

    // One checker per channel; result clears when a run starts and updates when it ends
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
            mlprs_lane_check #(
                .LANES (LANES)
            ) u_check (
                .clock_i    (clock_i),
                .rst_i      (rst_i),
                .start_i    (start_pulse),
                .active_i   (state == ST_RUN),
                .done_i     (done_pulse),
                .lane_sel_i (lane_test_sel_o[g*LANES +: LANES]),
                .lane_err_i (lane_s2[g*LANES +: LANES]),
                .result_o   (result_all[g*LANES +: LANES])
            );
        end
    endgenerate

    // Read mux; start bit, clear register and unmapped space read zero
    always @* begin
        rdata = 32'h00000000;
        if (ph_hit) begin
            case (ph_addr)
                `MLPRS_OFF_SELF_TEST:
                    rdata = 32'h00000000;
                `MLPRS_OFF_SYNC_CLR:
                    rdata = 32'h00000000;
                `MLPRS_OFF_INT_CLR:
                    rdata = 32'h00000000;
                `MLPRS_OFF_SYNC_STAT:
                    rdata[`MLPRS_FLAG_BIT] = sync_error_flag;
                `MLPRS_OFF_RES_CH0:
                    rdata[LANES-1:0] = result_all[0*LANES +: LANES];
                `MLPRS_OFF_RES_CH1:
                    rdata[LANES-1:0] = result_all[1*LANES +: LANES];
                `MLPRS_OFF_RES_CH2:
                    rdata[LANES-1:0] = result_all[2*LANES +: LANES];
                `MLPRS_OFF_RES_CH3:
                    rdata[LANES-1:0] = result_all[3*LANES +: LANES];
                `MLPRS_OFF_TEST_CTRL:
                    rdata = test_ctrl;
                `MLPRS_OFF_RUN_STAT:
                    rdata[`MLPRS_RUN_BIT] = link_test_running_o;
                `MLPRS_OFF_INT_STAT:
                    rdata[1:0] = int_stat;
                `MLPRS_OFF_INT_EN:
                    rdata[1:0] = int_en;
                default:
                    rdata = 32'h00000000;
            endcase
        end
    end
endmodule

// ### tb/mlprs_top_properties.sv
`timescale 1ns/1ps
`include "mlprs_regs.vh"
module mlprs_top_properties #(
    parameter CHANNELS  = 4,
    parameter LANES     = 8,
    parameter MS_CYCLES = 200000
) (
    input wire                      clock_i,
    input wire                      rst_i,
    input wire                      hsel_i,
    input wire [31:0]               haddr_i,
    input wire [1:0]                htrans_i,
    input wire                      hwrite_i,
    input wire                      hready_i,
    input wire [31:0]               hrdata_o,
    input wire                      hreadyout_o,
    input wire                      hresp_o,
    input wire                      link_test_running_o,
    input wire [CHANNELS*LANES-1:0] lane_test_sel_o
);
    wire        tk = hsel_i && htrans_i[1] && hready_i && haddr_i[31:8] == `MLPRS_BASE_HI;
    wire        rd = tk && !hwrite_i;
    wire [7:0]  off = haddr_i[7:0];
    reg  [31:0] run_cnt;
    // Counts the high cycles of a run so its length can be judged at the fall
    always @(posedge clock_i) begin
        if (rst_i || !link_test_running_o) begin
            run_cnt <= 32'h0;
        end else begin
            run_cnt <= run_cnt + 32'h1;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    read_wait_a: assert property (rd |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait state wrong");
    write_nowait_a: assert property (tk && hwrite_i |=> hreadyout_o)
        else $error("write stalled");
    resp_okay_a: assert property (!hresp_o)
        else $error("error response");
    stat_upper_a: assert property (rd && off == `MLPRS_OFF_SYNC_STAT |-> ##2 hrdata_o[31:1] == 31'h0)
        else $error("status upper bits set");
    res_upper_a: assert property (rd && off >= `MLPRS_OFF_RES_CH0 && off <= `MLPRS_OFF_RES_CH3
        |-> ##2 hrdata_o[31:8] == 24'h0)
        else $error("result upper bits set");
    start_zero_a: assert property (rd && off == `MLPRS_OFF_SELF_TEST |-> ##2 hrdata_o == 32'h0)
        else $error("start bit read nonzero");
    run_length_a: assert property ($fell(link_test_running_o) |-> run_cnt >= MS_CYCLES)
        else $error("run too short");
    sel_stable_a: assert property (link_test_running_o && $past(link_test_running_o)
        |-> $stable(lane_test_sel_o))
        else $error("lane selection moved mid-run");
endmodule
bind mlprs_top mlprs_top_properties #(.CHANNELS(CHANNELS), .LANES(LANES), .MS_CYCLES(MS_CYCLES)) chk (
    .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .link_test_running_o(link_test_running_o),
    .lane_test_sel_o(lane_test_sel_o));

// ### tb/mlprs_array_model.sv
`timescale 1ns/1ps
module mlprs_array_model (
    input  wire        clock_i,
    input  wire        running_i,
    input  wire [31:0] sel_i,
    input  wire [31:0] fail_mask_i,
    input  wire        sync_fault_i,
    output reg  [31:0] lane_err_o,
    output reg         sync_err_o
);
    initial begin
        lane_err_o = 32'h0;
        sync_err_o = 1'b0;
    end
    // Lane errors only during a run, so a result never depends on idle noise
    always @(posedge clock_i) begin
        lane_err_o <= running_i ? (sel_i & fail_mask_i) : 32'h0;
        sync_err_o <= sync_fault_i;
    end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "mlprs_regs.vh"
module testbench;
    reg         clock_i;
    reg         rst_i;
    reg         hsel_i;
    reg  [31:0] haddr_i;
    reg  [1:0]  htrans_i;
    reg         hwrite_i;
    reg  [31:0] hwdata_i;
    reg  [31:0] fail_mask;
    reg         sync_fault;
    reg         run_prev;
    reg  [31:0] run_len;
    reg  [31:0] rd;
    wire [31:0] hrdata_o;
    wire        hreadyout_o;
    wire        hresp_o;
    wire        sync_err;
    wire [31:0] lane_err;
    wire        running;
    wire [31:0] sel;
    wire        irq_o;
    integer     num_errors;
    integer     compares;
    integer     i;
    mlprs_top #(.MS_CYCLES(4)) DUT (
        .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .sync_err_i(sync_err), .lane_err_i(lane_err),
        .link_test_running_o(running), .lane_test_sel_o(sel), .irq_o(irq_o));
    mlprs_array_model arr (
        .clock_i(clock_i), .running_i(running), .sel_i(sel), .fail_mask_i(fail_mask),
        .sync_fault_i(sync_fault), .lane_err_o(lane_err), .sync_err_o(sync_err));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        run_prev <= running;
        if (running && !run_prev) begin
            run_len <= 32'h1;
        end else if (running) begin
            run_len <= run_len + 32'h1;
        end
    end
    task end_of_test;
        begin
            $display("errors %0d compares %0d", num_errors, compares);
            if (num_errors == 0 && compares > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task bus(input w, input [7:0] off, input [31:0] d);
        begin
            @(posedge clock_i);
            hsel_i   <= 1'b1;
            htrans_i <= 2'h2;
            hwrite_i <= w;
            haddr_i  <= {`MLPRS_BASE_HI, off};
            @(posedge clock_i);
            while (hreadyout_o !== 1'b1) @(posedge clock_i);
            hsel_i   <= 1'b0;
            htrans_i <= 2'h0;
            hwdata_i <= d;
            @(posedge clock_i);
            while (hreadyout_o !== 1'b1) @(posedge clock_i);
            rd = hrdata_o;
        end
    endtask
    task chk_rd(input [7:0] off, input [31:0] exp);
        begin
            bus(1'b0, off, 32'h0);
            check(rd, exp);
        end
    endtask
    task fault;
        begin
            sync_fault <= 1'b1;
            repeat (6) @(posedge clock_i);
            sync_fault <= 1'b0;
        end
    endtask
    task run(input [31:0] ctrl, input [31:0] cyc, input [31:0] exp, input [31:0] sx);
        begin
            bus(1'b1, `MLPRS_OFF_TEST_CTRL, ctrl);
            bus(1'b1, `MLPRS_OFF_SELF_TEST, 32'h1);
            chk_rd(`MLPRS_OFF_RUN_STAT, 32'h1);
            check(sel, sx);
            chk_rd(`MLPRS_OFF_SELF_TEST, 32'h0);
            for (i = 0; i < 1000 && running !== 1'b0; i = i + 1) @(posedge clock_i);
            repeat (2) @(posedge clock_i);
            check(run_len >= cyc && run_len <= cyc + 1, 32'h1);
            chk_rd(`MLPRS_OFF_RUN_STAT, 32'h0);
            for (i = 0; i < 4; i = i + 1)
                chk_rd(8'(`MLPRS_OFF_RES_CH0 + 4 * i), (exp >> (8 * i)) & 32'hFF);
        end
    endtask
    initial begin
        #100000;
        num_errors = num_errors + 1;
        end_of_test;
    end
    initial begin
        rst_i = 1'b1;
        hsel_i = 1'b0;
        haddr_i = 32'h0;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        hwdata_i = 32'h0;
        fail_mask = 32'h813C06A5;
        sync_fault = 1'b0;
        run_prev = 1'b0;
        run_len = 32'h0;
        num_errors = 0;
        compares = 0;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        chk_rd(`MLPRS_OFF_TEST_CTRL, 32'h0FFF0000);
        for (i = 0; i < 7; i = i + 1)
            chk_rd(8'(`MLPRS_OFF_SELF_TEST + 4 * i), 32'h0);
        bus(1'b1, `MLPRS_OFF_RES_CH0, 32'hFFFFFFFF);
        chk_rd(`MLPRS_OFF_RES_CH0, 32'h0);
        bus(1'b1, 8'h50, 32'hFFFFFFFF);
        chk_rd(8'h50, 32'h0);
        fault;
        chk_rd(`MLPRS_OFF_SYNC_STAT, 32'h1);
        check(irq_o, 32'h0);
        bus(1'b1, `MLPRS_OFF_INT_EN, 32'h1);
        repeat (2) @(posedge clock_i);
        check(irq_o, 32'h1);
        // Clear bit held for 500 ns before anything else
        bus(1'b1, `MLPRS_OFF_SYNC_CLR, 32'h1);
        repeat (100) @(posedge clock_i);
        chk_rd(`MLPRS_OFF_SYNC_STAT, 32'h0);
        fault;
        chk_rd(`MLPRS_OFF_SYNC_STAT, 32'h0);
        bus(1'b1, `MLPRS_OFF_SYNC_CLR, 32'h0);
        chk_rd(`MLPRS_OFF_SYNC_STAT, 32'h0);
        bus(1'b1, `MLPRS_OFF_INT_CLR, 32'h1);
        repeat (2) @(posedge clock_i);
        check(irq_o, 32'h0);
        fault;
        chk_rd(`MLPRS_OFF_SYNC_STAT, 32'h1);
        check(irq_o, 32'h1);
        bus(1'b1, `MLPRS_OFF_INT_EN, 32'h0);
        repeat (2) @(posedge clock_i);
        check(irq_o, 32'h0);
        run(32'h0FFF0003, 32'd12, 32'h7EC3F95A, 32'hFFFFFFFF);
        run(32'h00F20000, 32'd40, 32'h00000900, 32'h00000F00);
        end_of_test;
    end
endmodule
